// >>> common/spp_pkg.sv
package spp_pkg;
   // Port geometry
   localparam int PORT_W = 6;
   localparam int REG_W = 8;
   localparam int PIN_INPUT_ONLY = 3;
   localparam int PIN_TMR_CLK = 2;
   // Option register fields
   localparam int OPT_TMR_CS = 5;
   localparam int OPT_PU_DIS = 6;
   localparam int OPT_WU_DIS = 7;
   // Status register field
   localparam int STAT_WUF = 7;
   // Pins that carry pull-up and wake-on-change
   localparam logic [5:0] WPU_PINS = 6'h0B;
   // Reset values
   localparam logic [5:0] DIR_RST = 6'h3F;
   localparam logic [7:0] OPT_RST = 8'hFF;
   localparam logic [5:0] LATCH_RST = 6'h00;
   localparam logic [7:0] RDATA_RST = 8'h00;

   typedef enum logic [1:0] {
      SPP_RUN = 2'b00,
      SPP_SLEEP = 2'b01,
      SPP_WAKE = 2'b11
   } spp_mode_e;

   // One core instruction acting on the port, one cycle each
   typedef struct packed {
      logic rd;
      logic wr;
      logic bset;
      logic bclr;
      logic dir_ld;
      logic opt_ld;
      logic stat_rd;
      logic stat_wr;
      logic sleep;
      logic [2:0] bit_sel;
      logic [7:0] wdata;
   } spp_cmd_s;

   typedef struct packed {
      logic [5:0] out;
      logic [5:0] oe;
      logic [5:0] pull;
   } spp_pin_s;

   typedef struct packed {
      logic [5:0] latch;
      logic [5:0] dir;
      logic [7:0] opt;
      logic [7:0] rdata;
      logic wuf;
      logic [5:0] snap;
      spp_mode_e mode;
      spp_pin_s pin;
      logic wake;
   } spp_state_s;
endpackage

// >>> core/spp_port.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Only six low bits; bits 7:6 read zero
// - Port read returns live pin levels
// - Alternate-function pins read as zero
// - Bit 3 input only, never driven
// - Pull-up and wake on bits 0,1,3, shared
// - Reset pin select forces pull-up, no wake
// - Direction load copies W; one tri-states
// - Direction write-only, resets to all inputs
// - Timer external clock select forces bit 2 input
// - Reads sample pins, nothing is latched
// - Output latches hold until next write
// - Bit set/clear rewrite all latches from pins
// - Write lands at cycle end, read at start
// - Wake and pull-up controls active low, reset set
module spp_port (
   input wire logic CLK,
   input wire logic RST,
   input wire spp_pkg::spp_cmd_s CMD,
   input wire logic [5:0] ALT_FN_MASK,
   input wire logic RESET_PIN_SEL,
   input wire logic [5:0] PIN_IN,
   output logic [5:0] PIN_OUT,
   output logic [5:0] PIN_OE,
   output logic [5:0] PULL_EN,
   output logic [7:0] RD_DATA,
   output logic WAKE_FLAG,
   output logic WAKE,
   output logic SLEEPING
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   spp_pkg::spp_state_s st_r;
   spp_pkg::spp_state_s st_nxt;
   logic [5:0] pins_s;
   logic [5:0] rd_val;
   logic [5:0] wu_en;
   logic [7:0] sel8;
   logic [5:0] bit_mask;
   logic pin_change;

   ////////////////////////////////////////////////////////////////////////////
   // Pins come from outside; two flops before any logic looks at them
   spp_sync #(
      .W(spp_pkg::PORT_W)
   ) u_sync (
      .clk(CLK),
      .rst(RST),
      .d(PIN_IN),
      .q(pins_s)
   );

   // Wake compare covers only the shared pins, dropping bit 3 as reset
   always_comb begin
      wu_en = st_r.opt[spp_pkg::OPT_WU_DIS] ? 6'h00 : spp_pkg::WPU_PINS;
      if (RESET_PIN_SEL) begin
         wu_en[spp_pkg::PIN_INPUT_ONLY] = 1'b0;
      end
   end

   spp_wake #(
      .W(spp_pkg::PORT_W)
   ) u_wake (
      .pins(pins_s),
      .snap(st_r.snap),
      .en(wu_en),
      .change(pin_change)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read value and bit select
   always_comb begin
      rd_val = pins_s & ~ALT_FN_MASK;
      sel8 = 8'h01 << CMD.bit_sel;
      bit_mask = sel8[5:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state; one instruction per cycle, writes land at this cycle's end
   always_comb begin
      st_nxt = st_r;
      st_nxt.wake = 1'b0;
      // Reads sample at the start of the cycle; snapshot arms the wake compare
      if (CMD.rd || CMD.bset || CMD.bclr) begin
         st_nxt.rdata = {2'b00, rd_val};
         st_nxt.snap = pins_s;
      end
      if (CMD.stat_rd) begin
         st_nxt.rdata = {st_r.wuf, 7'h00};
      end
      // Latches load for every pin, driven or not
      if (CMD.wr) begin
         st_nxt.latch = CMD.wdata[5:0];
      end else if (CMD.bset) begin
         st_nxt.latch = rd_val | bit_mask;
      end else if (CMD.bclr) begin
         st_nxt.latch = rd_val & ~bit_mask;
      end
      if (CMD.dir_ld) begin
         st_nxt.dir = CMD.wdata[5:0];
      end
      if (CMD.opt_ld) begin
         st_nxt.opt = CMD.wdata;
      end
      // Software clear first, so a same-cycle wake still sets the flag
      if (CMD.stat_wr && !CMD.wdata[spp_pkg::STAT_WUF]) begin
         st_nxt.wuf = 1'b0;
      end
      // Sleep and wake sequencing
      case (st_r.mode)
         spp_pkg::SPP_RUN: begin
            if (CMD.sleep) begin
               st_nxt.mode = spp_pkg::SPP_SLEEP;
            end
         end
         spp_pkg::SPP_SLEEP: begin
            if (pin_change) begin
               st_nxt.mode = spp_pkg::SPP_WAKE;
               st_nxt.wuf = 1'b1;
               st_nxt.wake = 1'b1;
            end
         end
         spp_pkg::SPP_WAKE: begin
            st_nxt.mode = spp_pkg::SPP_RUN;
         end
         default: begin
            st_nxt.mode = spp_pkg::SPP_RUN;
         end
      endcase
      // Pin drivers follow the new latch and direction values
      st_nxt.pin.out = st_nxt.latch;
      st_nxt.pin.oe = ~st_nxt.dir;
      st_nxt.pin.oe[spp_pkg::PIN_INPUT_ONLY] = 1'b0;
      if (st_nxt.opt[spp_pkg::OPT_TMR_CS]) begin
         st_nxt.pin.oe[spp_pkg::PIN_TMR_CLK] = 1'b0;
      end
      // Pull-ups share one active-low enable
      st_nxt.pin.pull = st_nxt.opt[spp_pkg::OPT_PU_DIS] ? 6'h00 : spp_pkg::WPU_PINS;
      if (RESET_PIN_SEL) begin
         st_nxt.pin.pull[spp_pkg::PIN_INPUT_ONLY] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; reset leaves every pin an undriven input
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_r.latch <= spp_pkg::LATCH_RST;
         st_r.dir <= spp_pkg::DIR_RST;
         st_r.opt <= spp_pkg::OPT_RST;
         st_r.rdata <= spp_pkg::RDATA_RST;
         st_r.wuf <= 1'b0;
         st_r.snap <= 6'h00;
         st_r.mode <= spp_pkg::SPP_RUN;
         st_r.pin.out <= spp_pkg::LATCH_RST;
         st_r.pin.oe <= 6'h00;
         st_r.pin.pull <= 6'h00;
         st_r.wake <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign PIN_OUT = st_r.pin.out;
   assign PIN_OE = st_r.pin.oe;
   assign PULL_EN = st_r.pin.pull;
   assign RD_DATA = st_r.rdata;
   assign WAKE_FLAG = st_r.wuf;
   assign WAKE = st_r.wake;
   assign SLEEPING = (st_r.mode == spp_pkg::SPP_SLEEP);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   // Upper bits of a port read stay zero; a status read owns bit 7 instead
   unimpl_bits_a: assert property ((CMD.rd || CMD.bset || CMD.bclr) && !CMD.stat_rd |=> RD_DATA[7:6] == 2'b00)
      else $error("upper port bits not zero");

   // Port read returns masked live pins one cycle later
   read_pins_a: assert property (CMD.rd && !CMD.stat_rd |=>
      RD_DATA[5:0] == ($past(pins_s) & ~$past(ALT_FN_MASK)))
      else $error("port read mismatch");

   // Input-only pin never driven
   gp3_no_drive_a: assert property (!PIN_OE[spp_pkg::PIN_INPUT_ONLY])
      else $error("input-only pin driven");

   // Pull-ups only on the shared pins, bits 0 and 1 together
   pullup_shared_a: assert property ((PULL_EN & ~spp_pkg::WPU_PINS) == 6'h00
      && PULL_EN[0] == PULL_EN[1])
      else $error("pull-up on wrong pin");

   // Reset pin select forces the pull-up on bit 3
   reset_pull_a: assert property (!$past(RST) && $past(RESET_PIN_SEL) |-> PULL_EN[3])
      else $error("reset pin pull-up off");

   // Direction load drives the pin from the complement of W
   dir_load_a: assert property (CMD.dir_ld && !CMD.opt_ld |=>
      PIN_OE[1:0] == ~$past(CMD.wdata[1:0]) && PIN_OE[5:4] == ~$past(CMD.wdata[5:4]))
      else $error("direction load wrong");

   // After reset every pin is an input
   dir_reset_a: assert property ($past(RST) |-> st_r.dir == spp_pkg::DIR_RST
      && st_r.opt == spp_pkg::OPT_RST && PIN_OE == 6'h00)
      else $error("reset state wrong");

   // Timer external clock select keeps bit 2 undriven
   tmr_input_a: assert property (st_r.opt[spp_pkg::OPT_TMR_CS] |-> !PIN_OE[2])
      else $error("timer clock pin driven");

   // Latches hold without a port write
   latch_hold_a: assert property (!CMD.wr && !CMD.bset && !CMD.bclr |=> $stable(PIN_OUT))
      else $error("latch changed without write");

   // Write loads all latches, driven or not
   port_write_a: assert property (CMD.wr |=> PIN_OUT == $past(CMD.wdata[5:0]))
      else $error("port write lost");

   // Bit set rewrites every latch from the pins
   rmw_set_a: assert property (CMD.bset && !CMD.wr |=>
      PIN_OUT == ($past(rd_val) | $past(bit_mask)))
      else $error("bit set result wrong");

   // Pin change in sleep raises the flag and one wake pulse
   wake_flag_a: assert property (SLEEPING && pin_change |=> WAKE_FLAG && WAKE ##1 !WAKE)
      else $error("wake on change missed");
endmodule
`default_nettype wire

// >>> core/spp_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for pin levels
module spp_sync #(
   parameter int W = 6
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } spp_sync_s;

   spp_sync_s st_r;
   spp_sync_s st_nxt;

   if (W < 1) begin : g_bad_width
      $error("spp_sync: width must be at least one");
   end

   // First stage feeds only the second
   always_comb begin
      st_nxt.meta = d;
      st_nxt.sync = st_r.meta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.sync;
endmodule
`default_nettype wire

// >>> core/spp_wake.sv
`timescale 1ns/100ps
`default_nettype none
// Pin change detector against the levels seen at the last port read
module spp_wake #(
   parameter int W = 6
) (
   input wire logic [W-1:0] pins,
   input wire logic [W-1:0] snap,
   input wire logic [W-1:0] en,
   output logic change
);
   ////////////////////////////////////////////////////////////////////////////
   if (W < 1) begin : g_bad_width
      $error("spp_wake: width must be at least one");
   end

   // Any enabled pin that differs from its snapshot
   always_comb begin
      change = |((pins ^ snap) & en);
   end
endmodule
`default_nettype wire

// >>> test/spp_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
// External circuitry on the six port pins
module spp_pins_model (
   input wire logic clk,
   input wire logic [5:0] dev_out,
   input wire logic [5:0] dev_oe,
   input wire logic [5:0] pull,
   input wire logic [5:0] ext_val,
   input wire logic [5:0] ext_en,
   output logic [5:0] lvl
);
   logic [5:0] float_r = 6'h15;
   ////////////////////////////////////////////////////////////////////////////////
   // A floating pin keeps changing, so a stale level is never mistaken for a real one
   always_ff @(posedge clk) begin
      float_r <= ~float_r;
   end
   // Device driver wins; the outside backs off to avoid contention
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (dev_oe[i]) begin
            lvl[i] = dev_out[i];
         end else if (ext_en[i]) begin
            lvl[i] = ext_val[i]; // Held until the read
         end else if (pull[i]) begin
            lvl[i] = 1'b1;
         end else begin
            lvl[i] = float_r[i];
         end
      end
   end
endmodule
`default_nettype wire

// >>> test/spp_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
   $display("unexpected %s exp %h got %h", nm, exp, got); end end
module spp_port_tb;
   localparam logic [8:0] RD = 9'h100, WR = 9'h080, BS = 9'h040, BC = 9'h020, DL = 9'h010;
   localparam logic [8:0] OL = 9'h008, SR = 9'h004, SW = 9'h002, SL = 9'h001;
   logic clk = 1'b0;
   logic rst = 1'b1;
   spp_pkg::spp_cmd_s cmd = '0;
   logic [5:0] alt = 6'h00;
   logic rsel = 1'b1;
   logic [5:0] ext_val = 6'h00;
   logic [5:0] ext_en = 6'h3F;
   logic [5:0] lvl, pout, poe, pull;
   logic [7:0] rd;
   logic wflag, wake, slp;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   ////////////////////////////////////////////////////////////////////////////////
   always #4 clk = ~clk;
   spp_port u_spp_port (.CLK(clk), .RST(rst), .CMD(cmd), .ALT_FN_MASK(alt), .RESET_PIN_SEL(rsel),
      .PIN_IN(lvl), .PIN_OUT(pout), .PIN_OE(poe), .PULL_EN(pull), .RD_DATA(rd),
      .WAKE_FLAG(wflag), .WAKE(wake), .SLEEPING(slp));
   spp_pins_model u_spp_pins_model (.clk(clk), .dev_out(pout), .dev_oe(poe), .pull(pull),
      .ext_val(ext_val), .ext_en(ext_en), .lvl(lvl));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic spp_pkg::spp_cmd_s mk(input logic [8:0] f, input logic [2:0] b, input logic [7:0] d);
      mk = {f, b, d};
   endfunction
   // Instruction lands at the next rising edge; checks follow at the negedge after it
   task automatic put(input spp_pkg::spp_cmd_s k);
      @(negedge clk);
      cmd = k;
   endtask
   task automatic do1(input logic [8:0] f, input logic [2:0] b, input logic [7:0] d);
      put(mk(f, b, d));
      put('0);
   endtask
   task automatic idle(input int n);
      repeat (n) put('0);
   endtask
   // Bounded wait for the wake pulse, then check the wake outputs together
   task automatic wait_wake;
      for (int i = 0; i < 10 && wake !== 1'b1; i++) put('0);
      `CHK("wake", 1'b1, wake)
      `CHK("wake_flag", 1'b1, wflag)
      `CHK("sleeping", 1'b0, slp)
   endtask
   task automatic report_and_stop;
      if (n_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Hang guard, far above the fewer than one hundred cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         n_errors++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      idle(1);
      `CHK("oe", 6'h00, poe)
      `CHK("pull", 6'h08, pull)
      `CHK("flag", 1'b0, wflag)
      ext_val = 6'h2A;
      idle(3);
      do1(RD, 3'h0, 8'h00);
      `CHK("rd", 8'h2A, rd)
      alt = 6'h30;
      do1(RD, 3'h0, 8'h00);
      `CHK("rd alt", 8'h0A, rd)
      alt = 6'h00;
      do1(WR, 3'h0, 8'hFF);
      `CHK("out", 6'h3F, pout)
      `CHK("oe", 6'h00, poe)
      do1(DL, 3'h0, 8'h00);
      `CHK("oe", 6'h33, poe)
      do1(OL, 3'h0, 8'h00);
      `CHK("oe", 6'h37, poe)
      `CHK("pull", 6'h0B, pull)
      // Write then read back to back: the read still sees the old pins
      put(mk(WR, 3'h0, 8'h00));
      put(mk(RD, 3'h0, 8'h00));
      put('0);
      `CHK("rd", 8'h3F, rd)
      idle(3);
      do1(RD, 3'h0, 8'h00);
      `CHK("rd", 8'h08, rd)
      `CHK("out", 6'h00, pout)
      do1(DL, 3'h0, 8'h01);
      ext_val = 6'h09;
      idle(3);
      do1(BS, 3'h5, 8'h00);
      `CHK("out", 6'h29, pout)
      `CHK("rd", 8'h09, rd)
      idle(3);
      do1(BC, 3'h3, 8'h00);
      `CHK("out", 6'h21, pout)
      idle(3);
      do1(BS, 3'h6, 8'h00);
      `CHK("out", 6'h29, pout)
      do1(DL, 3'h0, 8'hFF);
      ext_en = 6'h00;
      idle(3);
      do1(RD, 3'h0, 8'h00);
      `CHK("rd pulled", 8'h0B, rd & 8'h0B)
      ext_en = 6'h3F;
      rsel = 1'b0;
      ext_val = 6'h00;
      idle(3);
      do1(RD, 3'h0, 8'h00);
      do1(SL, 3'h0, 8'h00);
      `CHK("sleeping", 1'b1, slp)
      ext_val = 6'h04;
      idle(6);
      `CHK("sleeping", 1'b1, slp)
      ext_val = 6'h06;
      wait_wake();
      idle(1);
      `CHK("wake", 1'b0, wake)
      do1(SR, 3'h0, 8'h00);
      `CHK("status", 8'h80, rd)
      do1(SW, 3'h0, 8'h00);
      `CHK("flag", 1'b0, wflag)
      rsel = 1'b1;
      idle(3);
      do1(RD, 3'h0, 8'h00);
      do1(SL, 3'h0, 8'h00);
      ext_val = 6'h0E;
      idle(6);
      `CHK("sleeping", 1'b1, slp)
      ext_val = 6'h0F;
      wait_wake();
      report_and_stop();
   end
endmodule
`default_nettype wire
